// ### drive_enable_sequencer.sv
// Purpose: Enable/disable sequencer for a servo power stage with AXI4-Lite registers.
// Assumes: All inputs synchronous to CLOCK; STANDSTILL comes from the speed loop.
// Notes:   Power gate, PWM gates and speed command all come from flip-flops.
//
// The address map and register access over AXI4-Lite were decided locally.

// ****************************************************************************
// Top module
// ****************************************************************************
// How it works
// - Hardware enable releases power stage at once
// - Software regulation takes over 2 ms later
// - Enabled flag shown in state word
// - Emergency stop ramps speed command to zero
// - Gate off 50 ms after standstill/ramp end
// - Power stage off 1.5 s at latest
// - Free coasting gates off immediately
// - Interface commands need enable and safety input
// - Mode bit 2 clear enables without delay
// - Mode bit 2 set ramps speed to zero
// - Software stop gates 50 ms after ramp
// - Software enable needs hardware enable
// - Missing enable suppresses internal PWM when the power stage goes off
// - Missing field enable blocks output PWM
// - Restart needs enable cycle after field returns
module drive_enable_sequencer
   import drive_seq_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // AXI4-Lite write address
   input wire logic [11:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address
   input wire logic [11:0] ARADDR,
   input wire logic [2:0] ARPROT,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Enable and safety inputs
   input wire logic HW_ENABLE_INPUT,
   input wire logic ROTATING_FIELD_ENABLE,
   input wire logic STANDSTILL,
   // Power stage controls
   output logic POWER_STAGE_EN,
   output logic SW_CONTROL,
   output logic CMD_READY,
   output logic PWM_INT_EN,
   output logic PWM_OUT_EN,
   output logic [15:0] SPEED_CMD_OUT
);

   // ************************************************************************
   // Helper functions
   // ************************************************************************

   // Word index decode, shared by read and write paths
   function automatic logic is_mapped(input logic [9:0] idx);
      is_mapped = (idx == IDX_STATE) || (idx == IDX_MODE) || (idx == IDX_MOTOR) ||
                  (idx == IDX_RAMP_TIME) || (idx == IDX_RAMP_STEP) ||
                  (idx == IDX_SPEED_CMD) || (idx == IDX_IO);
   endfunction : is_mapped

   // Byte-lane merge for strobed writes
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      merge = res;
   endfunction : merge

   // Move a signed value one step toward zero
   function automatic logic [15:0] toward_zero(input logic [15:0] v, input logic [15:0] step);
      logic signed [16:0] sv;
      logic signed [16:0] ss;
      sv = 17'(signed'(v));
      ss = signed'({1'b0, step});
      if (sv > ss) begin
         toward_zero = 16'(sv - ss);
      end else if (sv < -ss) begin
         toward_zero = 16'(sv + ss);
      end else begin
         toward_zero = 16'h0000;
      end
   endfunction : toward_zero

   // ************************************************************************
   // Declarations
   // ************************************************************************
   seq_state_t seq_q;
   seq_state_t seq_d;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_full_q, w_full_q;
   logic [9:0] aw_idx_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic do_write;
   logic mode_dis_q, free_q, lock_q, sw_stop_q, hw_prev_q;
   logic [15:0] ramp_time_q, ramp_step_q, speed_reg_q, speed_q;
   logic [16:0] pre_q;
   logic tick;
   logic [15:0] ms_q, tot_q;
   logic pwr_q, swc_q, cmdr_q, pwm_int_q, pwm_out_q;
   logic both_in, en_ok, ramp_done, stop_limit, clr_time;
   logic [31:0] state_word, io_word;
   logic [31:0] wr_word;

   // Register word as software sees it; shared by read data and write merge
   function automatic logic [31:0] reg_word(input logic [9:0] idx);
      unique case (idx)
         IDX_STATE: reg_word = state_word;
         IDX_MODE: reg_word = {29'h0, mode_dis_q, 2'b00};
         IDX_MOTOR: reg_word = {28'h0, free_q, 3'b000};
         IDX_RAMP_TIME: reg_word = {16'h0, ramp_time_q};
         IDX_RAMP_STEP: reg_word = {16'h0, ramp_step_q};
         IDX_SPEED_CMD: reg_word = {16'h0, speed_reg_q};
         IDX_IO: reg_word = io_word;
         default: reg_word = 32'h0000_0000;
      endcase
   endfunction : reg_word

   // ************************************************************************
   // AXI4-Lite write path
   // ************************************************************************

   // Address and data taken in either order; response after both
   assign do_write = aw_full_q && w_full_q && !bvalid_q;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         aw_idx_q <= 10'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         // Ready reopens only when idle, one write at a time
         if (!awready_q && !aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
         end
         if (!wready_q && !w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
         end
         if (AWVALID && awready_q) begin
            aw_idx_q <= AWADDR[11:2];
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (WVALID && wready_q) begin
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Old word with the strobed lanes replaced
   always_comb begin
      wr_word = merge(reg_word(aw_idx_q), wdata_q, wstrb_q);
   end

   // Software-writable registers; state and io words are read-only
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         mode_dis_q <= MODE_DIS_RST;
         free_q <= MOTOR_FREE_RST;
         ramp_time_q <= RAMP_TIME_RST;
         ramp_step_q <= RAMP_STEP_RST;
         speed_reg_q <= SPEED_CMD_RST;
      end else if (do_write) begin
         unique case (aw_idx_q)
            IDX_MODE: begin
               mode_dis_q <= wr_word[MODE_DIS_BIT];
            end
            IDX_MOTOR: begin
               free_q <= wr_word[MOTOR_FREE_BIT];
            end
            IDX_RAMP_TIME: begin
               ramp_time_q <= wr_word[15:0];
            end
            IDX_RAMP_STEP: begin
               ramp_step_q <= wr_word[15:0];
            end
            IDX_SPEED_CMD: begin
               speed_reg_q <= wr_word[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************************
   // AXI4-Lite read path
   // ************************************************************************

   // Status words built from live sequencer state
   always_comb begin
      state_word = 32'h0000_0000;
      state_word[ST_ENA_BIT] = (seq_q == ST_RUN);
      state_word[ST_RAMP0_BIT] = (seq_q == ST_RAMP) || (seq_q == ST_HOLD);
      state_word[ST_STILL_BIT] = STANDSTILL;
      state_word[ST_LOCK_BIT] = lock_q;
      io_word = 32'h0000_0000;
      io_word[IO_HW_BIT] = HW_ENABLE_INPUT;
      io_word[IO_RFE_BIT] = ROTATING_FIELD_ENABLE;
      io_word[IO_GO_BIT] = pwr_q;
   end

   // Data one cycle after the address is taken
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         if (!arready_q && !rvalid_q) begin
            arready_q <= 1'b1;
         end
         if (ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(ARADDR[11:2]) ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= reg_word(ARADDR[11:2]);
         end
         if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ************************************************************************
   // Millisecond time base
   // ************************************************************************

   // Prescaler restarts on every state change so delays start clean
   assign clr_time = (seq_d != seq_q) || (HW_ENABLE_INPUT != hw_prev_q);
   assign tick = (pre_q == 17'(CYCLES_PER_MS - 1));

   always_ff @(posedge CLOCK) begin
      if (!RST_N || clr_time) begin
         pre_q <= 17'h00000;
      end else if (tick) begin
         pre_q <= 17'h00000;
      end else begin
         pre_q <= pre_q + 17'h00001;
      end
   end

   // Time in current state, saturating
   always_ff @(posedge CLOCK) begin
      if (!RST_N || clr_time) begin
         ms_q <= 16'h0000;
      end else if (tick && ms_q != 16'hffff) begin
         ms_q <= ms_q + 16'h0001;
      end
   end

   // Time since the stop began; survives the ramp to hold step
   always_ff @(posedge CLOCK) begin
      if (!RST_N || seq_q == ST_RUN || seq_q == ST_OFF) begin
         tot_q <= 16'h0000;
      end else if (tick && tot_q != 16'hffff) begin
         tot_q <= tot_q + 16'h0001;
      end
   end

   // ************************************************************************
   // Enable sequencer
   // ************************************************************************

   // Interface commands act only with both hardware inputs present
   assign both_in = HW_ENABLE_INPUT && ROTATING_FIELD_ENABLE;
   assign en_ok = both_in && !mode_dis_q && !lock_q;
   assign ramp_done = (ms_q >= ramp_time_q);
   // One count early: a partial ms may be lost when hold starts
   assign stop_limit = (tot_q >= T_STOP_MAX_MS - 16'd1);

   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         ST_OFF: begin
            if (en_ok) begin
               seq_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!ROTATING_FIELD_ENABLE) begin
               seq_d = ST_OFF;
            end else if (!HW_ENABLE_INPUT) begin
               seq_d = free_q ? ST_OFF : ST_RAMP;
            end else if (mode_dis_q) begin
               seq_d = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (!ROTATING_FIELD_ENABLE || stop_limit) begin
               seq_d = ST_OFF;
            end else if (en_ok) begin
               seq_d = ST_RUN;
            end else if (ramp_done || (STANDSTILL && !sw_stop_q)) begin
               seq_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!ROTATING_FIELD_ENABLE || stop_limit || ms_q >= T_GATE_OFF_MS) begin
               seq_d = ST_OFF;
            end else if (en_ok) begin
               seq_d = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         seq_q <= ST_OFF;
      end else begin
         seq_q <= seq_d;
      end
   end

   // Remember whether the stop was commanded by software
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         sw_stop_q <= 1'b0;
      end else if (seq_q == ST_RUN && seq_d == ST_RAMP) begin
         sw_stop_q <= HW_ENABLE_INPUT;
      end
   end

   // Restart lockout: field loss must be followed by an enable cycle
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         lock_q <= LOCK_RST;
         hw_prev_q <= 1'b0;
      end else begin
         hw_prev_q <= HW_ENABLE_INPUT;
         if (!ROTATING_FIELD_ENABLE) begin
            lock_q <= 1'b1;
         end else if (!HW_ENABLE_INPUT) begin
            lock_q <= 1'b0;
         end
      end
   end

   // Internal speed command: follows software while running, ramps when stopping
   always_ff @(posedge CLOCK) begin
      if (!RST_N || seq_d == ST_OFF) begin
         speed_q <= 16'h0000;
      end else if (seq_d == ST_RUN) begin
         speed_q <= speed_reg_q;
      end else if (tick) begin
         speed_q <= toward_zero(speed_q, ramp_step_q);
      end
   end

   // ************************************************************************
   // Output flops
   // ************************************************************************

   // Gates follow the next state so release costs one edge only
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         pwr_q <= 1'b0;
         swc_q <= 1'b0;
         cmdr_q <= 1'b0;
         pwm_int_q <= 1'b0;
         pwm_out_q <= 1'b0;
      end else begin
         pwr_q <= (seq_d != ST_OFF);
         swc_q <= (seq_d == ST_RUN) && !clr_time && (ms_q >= T_SW_CTRL_MS);
         cmdr_q <= (seq_d == ST_RUN) && !clr_time && (ms_q >= T_CMD_READY_MS);
         pwm_int_q <= (seq_d != ST_OFF);
         pwm_out_q <= (seq_d != ST_OFF) && ROTATING_FIELD_ENABLE;
      end
   end

   assign AWREADY = awready_q;
   assign WREADY = wready_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;
   assign POWER_STAGE_EN = pwr_q;
   assign SW_CONTROL = swc_q;
   assign CMD_READY = cmdr_q;
   assign PWM_INT_EN = pwm_int_q;
   assign PWM_OUT_EN = pwm_out_q;
   assign SPEED_CMD_OUT = speed_q;

endmodule : drive_enable_sequencer

// ### drive_enable_sequencer_checker.sv
// Purpose: Port checks for the drive enable sequencer.
// Assumes: CYCLES_PER_MS equals the value of the bound instance.
// Notes:   Time windows allow a few cycles of register slack.

// ****************************************
// Checker
// ****************************************
module seq_checker #(
   parameter int unsigned CYCLES_PER_MS = 10
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Bus handshakes
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic BVALID,
   input wire logic BREADY,
   // Drive side
   input wire logic HW_ENABLE_INPUT,
   input wire logic ROTATING_FIELD_ENABLE,
   input wire logic STANDSTILL,
   input wire logic POWER_STAGE_EN,
   input wire logic SW_CONTROL,
   input wire logic CMD_READY,
   input wire logic PWM_INT_EN,
   input wire logic PWM_OUT_EN
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int C = CYCLES_PER_MS;
   int run_q;
   int stop_q;
   int still_q;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   // Cycles with the gate open and the enable present; a hardware stop restarts it
   always_ff @(posedge CLOCK) begin
      run_q <= (RST_N && POWER_STAGE_EN && HW_ENABLE_INPUT) ? run_q + 1 : 0;
   end
   // Cycles of a hardware stop; counters avoid huge repetitions
   always_ff @(posedge CLOCK) begin
      stop_q <= (RST_N && POWER_STAGE_EN && !HW_ENABLE_INPUT) ? stop_q + 1 : 0;
   end
   // Cycles at standstill while stopping
   always_ff @(posedge CLOCK) begin
      still_q <= (RST_N && POWER_STAGE_EN && !HW_ENABLE_INPUT && STANDSTILL) ?
         still_q + 1 : 0;
   end

   pwr_cause_a: assert property ($rose(POWER_STAGE_EN) |->
      $past(HW_ENABLE_INPUT) && $past(ROTATING_FIELD_ENABLE))
      else $error("gate opened without both enables");
   field_off_a: assert property (!ROTATING_FIELD_ENABLE |-> ##2
      !POWER_STAGE_EN && !PWM_OUT_EN)
      else $error("field loss left the gate open");
   pwm_int_a: assert property (PWM_INT_EN == POWER_STAGE_EN)
      else $error("internal pwm differs from gate");
   pwm_out_a: assert property (PWM_OUT_EN |-> PWM_INT_EN)
      else $error("output pwm without internal pwm");
   sw_time_a: assert property ($rose(SW_CONTROL) |-> run_q inside {[2*C-2:2*C+3]})
      else $error("soft control handover mistimed");
   cmd_time_a: assert property ($rose(CMD_READY) |-> run_q inside {[5*C-2:5*C+3]})
      else $error("command ready mistimed");
   sw_drop_a: assert property (!HW_ENABLE_INPUT |-> ##2 !SW_CONTROL && !CMD_READY)
      else $error("soft control without hardware enable");
   stop_max_a: assert property (stop_q <= 1500 * C)
      else $error("stop ran past its limit");
   still_gate_a: assert property (still_q <= 50 * C + 3)
      else $error("gate held too long after standstill");
   wr_done_a: assert property (BVALID && BREADY |=> !BVALID)
      else $error("write response repeated");
   rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
endmodule : seq_checker

bind drive_enable_sequencer seq_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) seq_checker_i (.*);

// ### drive_partner.sv
// Purpose: Controller and safety switching device facing the drive.
// Assumes: Tasks are called just after a rising clock edge.
// Notes:   Levels change by non-blocking assignment only.

// ****************************************
// Partner model
// ****************************************
module drive_partner #(
   parameter int unsigned CYCLES_PER_MS = 10
) (
   // Clock
   input wire logic clock,
   // Enables and axis status
   output logic hw_en,
   output logic field_en,
   output logic still
);
   timeunit 1ns;
   timeprecision 1ns;

   // Safety contacts open at start
   initial begin
      hw_en = 1'b0;
      field_en = 1'b0;
      still = 1'b0;
   end
   task automatic wait_ms(input int n);
      repeat (n * CYCLES_PER_MS) @(posedge clock);
   endtask : wait_ms
   task automatic drive(input logic h, input logic f, input logic s);
      hw_en <= h;
      field_en <= f;
      still <= s;
   endtask : drive
   // Field first, hardware enable half a second later
   task automatic power_on();
      drive(1'b0, 1'b1, 1'b0);
      wait_ms(500);
      hw_en <= 1'b1;
   endtask : power_on
   // Enable cycled once the field is back
   task automatic rearm();
      hw_en <= 1'b0;
      wait_ms(1);
      hw_en <= 1'b1;
   endtask : rearm
   // Commands held back until the drive has settled
   task automatic settle();
      wait_ms(6);
   endtask : settle
endmodule : drive_partner

// ### drive_seq_pkg.sv
// Purpose: Shared constants and types for the drive enable sequencer.
// Assumes: 100 MHz system clock, AXI4-Lite register access, 32-bit data.
// Notes:   Register indices are word indices; byte address is four times the index.

// ****************************************************************************
// Constants and types
// ****************************************************************************
package drive_seq_pkg;

   // Clock and time base
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CYCLES_PER_MS_DEF = CLK_HZ / 1000;

   // Delays in ms as printed, and the stop limit in seconds
   localparam logic [15:0] T_SW_CTRL_MS = 16'd2;
   localparam logic [15:0] T_CMD_READY_MS = 16'd5;
   localparam logic [15:0] T_GATE_OFF_MS = 16'd50;
   localparam real T_STOP_MAX_S = 1.5;
   localparam logic [15:0] T_STOP_MAX_MS = 16'(int'(T_STOP_MAX_S * 1000.0));

   // Register word indices
   localparam logic [9:0] IDX_STATE = 10'h040;
   localparam logic [9:0] IDX_MODE = 10'h051;
   localparam logic [9:0] IDX_MOTOR = 10'h05a;
   localparam logic [9:0] IDX_RAMP_TIME = 10'h070;
   localparam logic [9:0] IDX_RAMP_STEP = 10'h071;
   localparam logic [9:0] IDX_SPEED_CMD = 10'h072;
   localparam logic [9:0] IDX_IO = 10'h0d8;

   // Field positions
   localparam int unsigned MODE_DIS_BIT = 2;
   localparam int unsigned MOTOR_FREE_BIT = 3;
   localparam int unsigned ST_ENA_BIT = 0;
   localparam int unsigned ST_RAMP0_BIT = 1;
   localparam int unsigned ST_STILL_BIT = 9;
   localparam int unsigned ST_LOCK_BIT = 30;
   localparam int unsigned IO_HW_BIT = 4;
   localparam int unsigned IO_RFE_BIT = 5;
   localparam int unsigned IO_GO_BIT = 11;

   // Values after reset
   localparam logic [15:0] RAMP_TIME_RST = 16'd5000;
   localparam logic [15:0] RAMP_STEP_RST = 16'h0010;
   localparam logic [15:0] SPEED_CMD_RST = 16'h0000;
   localparam logic MODE_DIS_RST = 1'b0;
   localparam logic MOTOR_FREE_RST = 1'b0;
   localparam logic LOCK_RST = 1'b1;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Sequencer states
   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_RAMP, ST_HOLD} seq_state_t;

endpackage : drive_seq_pkg

// ### tb_drive_enable_sequencer.sv
// Purpose: Self-checking bench for the drive enable sequencer.
// Assumes: One millisecond shortened to ten cycles.
// Notes:   Bus answers are checked from queues by a monitor.

// ****************************************
// Testbench
// ****************************************
module tb_drive_enable_sequencer
   import drive_seq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int C = 10;
   localparam int CMD = (T_CMD_READY_MS - T_SW_CTRL_MS) * C;
   localparam int GATE = T_GATE_OFF_MS * C;
   localparam int STOP = T_STOP_MAX_MS * C;
   logic CLOCK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [11:0] AWADDR, ARADDR;
   logic [2:0] AWPROT, ARPROT;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic HW_ENABLE_INPUT, ROTATING_FIELD_ENABLE, STANDSTILL;
   logic POWER_STAGE_EN, SW_CONTROL, CMD_READY, PWM_INT_EN, PWM_OUT_EN;
   logic [15:0] SPEED_CMD_OUT, spd;
   logic [1:0] exp_b[$];
   logic [33:0] exp_r[$];
   int bad_count, num_checks, n;
   int seed = 32'h9be7;

   drive_enable_sequencer #(.CYCLES_PER_MS(C)) drive_enable_sequencer_i (.*);
   drive_partner #(.CYCLES_PER_MS(C)) drive_partner_i (
      .clock(CLOCK),
      .hw_en(HW_ENABLE_INPUT),
      .field_en(ROTATING_FIELD_ENABLE),
      .still(STANDSTILL)
   );

   // 100 MHz clock
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   task automatic chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   // Oldest note against each completed answer
   always @(posedge CLOCK) begin
      if (BVALID && BREADY) chk(exp_b.size() > 0 && BRESP === exp_b.pop_front(), "bresp");
      if (RVALID && RREADY) chk(exp_r.size() > 0 && {RRESP, RDATA} === exp_r.pop_front(),
         "read");
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_b.push_back(r);
      {AWADDR, WDATA, AWPROT} <= {a, d, 3'($random(seed))};
      {AWVALID, WVALID, BREADY} <= 3'b111;
      for (int i = 0; i < 50; i++) begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) break;
      end
      BREADY <= 1'b0;
      @(posedge CLOCK);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_r.push_back({r, d});
      {ARADDR, ARPROT} <= {a, 3'($random(seed))};
      {ARVALID, RREADY} <= 2'b11;
      for (int i = 0; i < 50; i++) begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
         if (RVALID) break;
      end
      RREADY <= 1'b0;
      @(posedge CLOCK);
   endtask : rd
   function automatic logic pin(input int s);
      return s == 0 ? POWER_STAGE_EN : s == 1 ? SW_CONTROL : CMD_READY;
   endfunction : pin
   // Edges until an output reaches a level, against a window
   task automatic expect_pin(input int s, input logic v, input int lo, input int hi, string m);
      for (n = 0; n <= hi && pin(s) !== v; n++) @(posedge CLOCK);
      chk(n >= lo && n <= hi, m);
   endtask : expect_pin
   task automatic finish_test();
      bad_count += exp_b.size() + exp_r.size();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   // Hang guard, about a third again the expected run
   initial begin
      repeat (30000) @(posedge CLOCK);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      finish_test();
   end

   // Main sequence
   initial begin
      RST_N = 1'b0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, AWPROT, ARPROT, WDATA} = '0;
      WSTRB = 4'hf;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      @(posedge CLOCK);
      rd(12'h100, 32'h4000_0000);
      rd(12'h1c0, 32'(RAMP_TIME_RST));
      rd(12'h1c4, 32'(RAMP_STEP_RST));
      rd(12'h1c8, '0);
      rd(12'h144, '0);
      rd(12'h168, '0);
      rd(12'h360, '0);
      rd(12'h004, '0, RESP_SLVERR);
      wr(12'h004, '1, RESP_SLVERR);
      wr(12'h100, 32'h1);
      rd(12'h100, 32'h4000_0000);
      $display("test registers done");
      drive_partner_i.power_on();
      expect_pin(0, 1'b1, 1, 3, "release");
      chk(PWM_OUT_EN === 1'b1, "output pwm");
      expect_pin(1, 1'b1, T_SW_CTRL_MS * C - 2, T_SW_CTRL_MS * C + 3, "handover");
      expect_pin(2, 1'b1, CMD - 3, CMD + 3, "command ready");
      rd(12'h100, 32'h1);
      rd(12'h360, 32'h830);
      spd = 16'h0100 + 16'($random(seed) & 'hff);
      wr(12'h1c8, {16'h0, spd});
      chk(SPEED_CMD_OUT === spd, "speed pass");
      wr(12'h1c0, 32'd8);
      drive_partner_i.drive(1'b0, 1'b1, 1'b0);
      expect_pin(1, 1'b0, 0, 3, "handover drop");
      drive_partner_i.wait_ms(4);
      chk(SPEED_CMD_OUT <= spd - 16'h30 && SPEED_CMD_OUT >= spd - 16'h50, "ramp");
      expect_pin(0, 1'b0, GATE + 2 * C, GATE + 6 * C, "gate after ramp");
      $display("test emergency stop done");
      wr(12'h1c0, 32'd2000);
      drive_partner_i.drive(1'b1, 1'b1, 1'b0);
      expect_pin(0, 1'b1, 1, 3, "release");
      drive_partner_i.drive(1'b0, 1'b1, 1'b0);
      drive_partner_i.wait_ms(3);
      drive_partner_i.drive(1'b0, 1'b1, 1'b1);
      expect_pin(0, 1'b0, GATE - 2, GATE + 4, "gate after standstill");
      drive_partner_i.drive(1'b1, 1'b1, 1'b0);
      expect_pin(0, 1'b1, 1, 3, "release");
      drive_partner_i.drive(1'b0, 1'b1, 1'b0);
      expect_pin(0, 1'b0, STOP - C - 3, STOP + 2, "stop limit");
      $display("test standstill and limit done");
      wr(12'h168, 32'h8);
      drive_partner_i.drive(1'b1, 1'b1, 1'b0);
      expect_pin(0, 1'b1, 1, 3, "release");
      drive_partner_i.drive(1'b0, 1'b1, 1'b0);
      expect_pin(0, 1'b0, 0, 3, "free coasting");
      wr(12'h168, 32'h0);
      wr(12'h1c0, 32'd3);
      drive_partner_i.drive(1'b1, 1'b1, 1'b0);
      drive_partner_i.settle();
      wr(12'h144, 32'h4);
      expect_pin(1, 1'b0, 0, 3, "soft stop");
      expect_pin(0, 1'b0, GATE + 2 * C, GATE + 4 * C, "gate after soft ramp");
      rd(12'h144, 32'h4);
      wr(12'h144, 32'h0);
      expect_pin(0, 1'b1, 0, 3, "soft enable");
      $display("test coasting and software done");
      drive_partner_i.drive(1'b1, 1'b0, 1'b0);
      expect_pin(0, 1'b0, 1, 3, "field loss");
      chk(PWM_OUT_EN === 1'b0, "output pwm off");
      drive_partner_i.drive(1'b1, 1'b1, 1'b0);
      drive_partner_i.wait_ms(2);
      chk(POWER_STAGE_EN === 1'b0, "restart lock");
      rd(12'h100, 32'h4000_0000);
      drive_partner_i.rearm();
      expect_pin(0, 1'b1, 1, 3, "restart");
      $display("test safety done");
      finish_test();
   end
endmodule : tb_drive_enable_sequencer
